// File: design/ccta_chan.v
/*
 * one capture/compare channel: compare value, capture logic and output unit.
 * assumes the counter value and its one-cycle update strobe from the timer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccta_consts.vh"

module ccta_chan (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // counter view
  input  wire [15:0] cnt,
  input  wire        cnt_upd,
  input  wire        eq0_evt,
  // configuration
  input  wire        cap_mode,
  input  wire [1:0]  cap_edge,
  input  wire [1:0]  capture_input_select,
  input  wire [2:0]  out_mode,
  input  wire        out_bit,
  // inputs
  input  wire        pin_in,
  input  wire        alt_in,
  // compare value write
  input  wire        ccr_wr,
  input  wire [15:0] ccr_wdata,
  // results
  output reg  [15:0] ccr_r,
  output wire        cc_evt,
  output reg         out_r
);

  reg  cin_prev_r;
  reg  cin;
  wire rise;
  wire fall;
  wire cap_evt;
  wire eq_evt;

  // capture input mux; gnd/vcc selection lets software force an edge
  // [R9] [R10] [R11] input source choice
  always @* begin
    case (capture_input_select)
      `CCTA_CIS_PIN: cin = pin_in;
      `CCTA_CIS_ALT: cin = alt_in;
      `CCTA_CIS_GND: cin = 1'b0;
      default:       cin = 1'b1;
    endcase
  end

  // previous input level for edge detection
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cin_prev_r <= 1'b0;
    end else begin
      cin_prev_r <= cin;
    end
  end

  assign rise = cin & ~cin_prev_r;
  assign fall = ~cin & cin_prev_r;
  // [R7] [R8] edge select, none disables
  assign cap_evt = cap_mode & (((cap_edge == `CCTA_EDGE_RISE) & rise) |
                               ((cap_edge == `CCTA_EDGE_FALL) & fall) |
                               ((cap_edge == `CCTA_EDGE_BOTH) & (rise | fall)));
  assign eq_evt  = ~cap_mode & cnt_upd & (cnt == ccr_r);
  // [R6] one event per mode
  assign cc_evt  = cap_evt | eq_evt;

  // compare value register, loaded by software or by a capture
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccr_r <= `CCTA_CCR_RST;
    end else if (cap_evt) begin
      // [R7] latch counter
      ccr_r <= cnt;
    end else if (ccr_wr) begin
      ccr_r <= ccr_wdata;
    end
  end

  // output unit: first action on own match, second on period match
  // [R12] output unit modes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else begin
      case (out_mode)
        `CCTA_OUT_BIT:     out_r <= out_bit;
        `CCTA_OUT_SET:     if (eq_evt) out_r <= 1'b1;
        `CCTA_OUT_TGL_RST: if (eq_evt) out_r <= ~out_r; else if (eq0_evt) out_r <= 1'b0;
        `CCTA_OUT_SET_RST: if (eq_evt) out_r <= 1'b1; else if (eq0_evt) out_r <= 1'b0;
        `CCTA_OUT_TGL:     if (eq_evt) out_r <= ~out_r;
        `CCTA_OUT_RST:     if (eq_evt) out_r <= 1'b0;
        `CCTA_OUT_TGL_SET: if (eq_evt) out_r <= ~out_r; else if (eq0_evt) out_r <= 1'b1;
        default:           if (eq_evt) out_r <= 1'b0; else if (eq0_evt) out_r <= 1'b1;
      endcase
    end
  end

endmodule // ccta_chan

`default_nettype wire

// File: design/ccta_consts.vh
/*
 * constants of the three-channel capture/compare timer: selector codes,
 * counter modes, capture edges, output unit modes and vector word values.
 * assumes nothing; included by every timer source file.
 */
`ifndef CCTA_CONSTS_VH
`define CCTA_CONSTS_VH

// ==========================================================================
// count clock source selector
`define CCTA_SRC_EXT_A    2'h0
`define CCTA_SRC_AUX      2'h1
`define CCTA_SRC_PERIPH   2'h2
`define CCTA_SRC_EXT_B    2'h3

// ==========================================================================
// counter modes
`define CCTA_MODE_STOP    2'h0
`define CCTA_MODE_UP      2'h1
`define CCTA_MODE_CONT    2'h2
`define CCTA_MODE_UPDN    2'h3

// ==========================================================================
// capture edge select (none disables capturing)
`define CCTA_EDGE_NONE    2'h0
`define CCTA_EDGE_RISE    2'h1
`define CCTA_EDGE_FALL    2'h2
`define CCTA_EDGE_BOTH    2'h3

// ==========================================================================
// capture input select
`define CCTA_CIS_PIN      2'h0
`define CCTA_CIS_ALT      2'h1
`define CCTA_CIS_GND      2'h2
`define CCTA_CIS_VCC      2'h3

// ==========================================================================
// output unit modes
`define CCTA_OUT_BIT      3'h0
`define CCTA_OUT_SET      3'h1
`define CCTA_OUT_TGL_RST  3'h2
`define CCTA_OUT_SET_RST  3'h3
`define CCTA_OUT_TGL      3'h4
`define CCTA_OUT_RST      3'h5
`define CCTA_OUT_TGL_SET  3'h6
`define CCTA_OUT_RST_SET  3'h7

// ==========================================================================
// shared vector word values and reset values
`define CCTA_IV_NONE      4'h0
`define CCTA_IV_CC1       4'h2
`define CCTA_IV_CC2       4'h4
`define CCTA_IV_OVF       4'ha
`define CCTA_CNT_RST      16'h0000
`define CCTA_CCR_RST      16'h0000

`endif

// File: design/ccta_timer.v
/*
 * sixteen-bit timer with three capture/compare channels, clock source
 * select, prescaler, counter modes, output units and two interrupt lines.
 * assumes all inputs synchronous to ref_clk; source clocks are sampled
 * levels and count on their rising edge, so they must be slower than
 * half of ref_clk. control bits are plain ports, no register bus.
 */
// Functional notes
// [R1] source select: pin a, aux, peripheral, pin b
// [R2] prescaler divides by one, two, four, eight
// [R3] one sixteen-bit counter, three channels
// [R4] software halts, reads, writes full counter
// [R5] stop, continuous, up, up/down; channel zero period
// [R6] each channel capture or compare
// [R7] capture on rise, fall or both
// [R8] capturing can be disabled
// [R9] one external event pin per channel
// [R10] channel two alternate input is aux clock
// [R11] selector values two, three: software capture
// [R12] output unit per channel, several modes
// [R13] channel zero irq, shared irq for rest
// [R14] vector word names pending shared source
// [R15] vector zero when idle, else priority offsets
// [R16] sticky flags, enable gates request
`timescale 1ns/1ps
`default_nettype none
`include "ccta_consts.vh"

module ccta_timer #(
  parameter CHANS = 3
) (
  // clock and reset
  input  wire               ref_clk,
  input  wire               rst_n,
  // count clock sources
  input  wire               ext_count_clk_a,
  input  wire               ext_count_clk_b,
  input  wire               aux_clk,
  input  wire               peripheral_sub_clock,
  // counter control
  input  wire [1:0]         src_sel,
  input  wire [1:0]         div_sel,
  input  wire [1:0]         mode_sel,
  input  wire               cnt_clr,
  input  wire               cnt_wr,
  input  wire [15:0]        cnt_wdata,
  output wire [15:0]        cnt_value,
  // channel configuration, channel n in slice n
  input  wire [CHANS-1:0]   cap_mode,
  input  wire [2*CHANS-1:0] cap_edge,
  input  wire [2*CHANS-1:0] capture_input_select,
  input  wire [3*CHANS-1:0] out_mode,
  input  wire [CHANS-1:0]   out_bit,
  input  wire [CHANS-1:0]   ccr_wr,
  input  wire [15:0]        ccr_wdata,
  output wire [16*CHANS-1:0] ccr_value,
  // event pins and compare outputs
  input  wire               event_pin_zero,
  input  wire               event_pin_one,
  input  wire               event_pin_two,
  output wire [CHANS-1:0]   cmp_out,
  // interrupt flags: bit 0 channel zero, 1 one, 2 two, 3 overflow
  input  wire [3:0]         irq_en,
  input  wire [3:0]         flag_clr,
  input  wire               iv_ack,
  output wire [3:0]         flags,
  output wire [3:0]         int_vector,
  output wire               irq_cc_zero,
  output wire               irq_shared
);

  reg  [15:0] cnt_r;
  reg         dir_down_r;
  reg         src_prev_r;
  reg  [2:0]  div_r;
  reg         upd_r;
  reg  [3:0]  flag_r;
  reg         src_lvl;
  reg  [15:0] cnt_nxt;
  reg         dir_nxt;
  reg         ovf_evt;
  reg  [3:0]  iv_nxt;
  reg  [3:0]  ack_clr;
  wire        src_edge;
  wire        tick;
  wire [2:0]  div_max;
  wire [15:0] period;
  wire        eq0_evt;
  wire [CHANS-1:0] pins;
  wire [CHANS-1:0] alts;
  wire [CHANS-1:0] cc_evt;

  // ========================================================================
  // count clock selection and prescaler

  // source mux
  // [R1] source selector
  always @* begin
    case (src_sel)
      `CCTA_SRC_EXT_A:  src_lvl = ext_count_clk_a;
      `CCTA_SRC_AUX:    src_lvl = aux_clk;
      `CCTA_SRC_PERIPH: src_lvl = peripheral_sub_clock;
      default:          src_lvl = ext_count_clk_b;
    endcase
  end

  assign src_edge = src_lvl & ~src_prev_r;
  assign div_max  = (3'h1 << div_sel) - 3'h1;
  // [R2] divided tick
  assign tick     = src_edge & (div_r == div_max) & (mode_sel != `CCTA_MODE_STOP);

  // edge detector and divider; the divider clears to zero while stopped
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_r <= 1'b0;
      div_r      <= 3'h0;
    end else begin
      src_prev_r <= src_lvl;
      if (cnt_clr || mode_sel == `CCTA_MODE_STOP) begin
        div_r <= 3'h0;
      end else if (src_edge) begin
        div_r <= (div_r >= div_max) ? 3'h0 : div_r + 3'h1;
      end
    end
  end

  // ========================================================================
  // counter

  assign period = ccr_value[15:0];

  // next count by mode; overflow marks the return to zero
  // [R5] counting modes
  always @* begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_down_r;
    ovf_evt = 1'b0;
    case (mode_sel)
      `CCTA_MODE_UP: begin
        if (cnt_r >= period) begin
          cnt_nxt = 16'h0000;
          ovf_evt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      `CCTA_MODE_CONT: begin
        cnt_nxt = cnt_r + 16'h0001;
        ovf_evt = (cnt_r == 16'hffff);
      end
      `CCTA_MODE_UPDN: begin
        if (!dir_down_r) begin
          if (cnt_r >= period) begin
            dir_nxt = 1'b1;
            cnt_nxt = (period == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end else if (cnt_r == 16'h0001 || cnt_r == 16'h0000) begin
          cnt_nxt = 16'h0000;
          dir_nxt = 1'b0;
          ovf_evt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      default: begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  // counter register, software write and clear win over counting
  // [R3] [R4] counter access
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= `CCTA_CNT_RST;
      dir_down_r <= 1'b0;
      upd_r      <= 1'b0;
    end else begin
      upd_r <= tick | cnt_wr | cnt_clr;
      if (cnt_clr) begin
        cnt_r      <= `CCTA_CNT_RST;
        dir_down_r <= 1'b0;
      end else if (cnt_wr) begin
        cnt_r <= cnt_wdata;
      end else if (tick) begin
        cnt_r      <= cnt_nxt;
        dir_down_r <= dir_nxt;
      end
    end
  end

  assign cnt_value = cnt_r;
  assign eq0_evt   = upd_r & (cnt_r == period);

  // ========================================================================
  // capture/compare channels

  assign pins = {event_pin_two, event_pin_one, event_pin_zero};
  // [R10] aux clock on channel two
  assign alts = {aux_clk, 1'b0, 1'b0};

  // [R6] [R9] per-channel instances
  genvar gi;
  generate
    for (gi = 0; gi < CHANS; gi = gi + 1) begin : g_chan
      ccta_chan u_chan (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .cnt                  (cnt_r),
        .cnt_upd              (upd_r),
        .eq0_evt              (eq0_evt),
        .cap_mode             (cap_mode[gi]),
        .cap_edge             (cap_edge[2*gi +: 2]),
        .capture_input_select (capture_input_select[2*gi +: 2]),
        .out_mode             (out_mode[3*gi +: 3]),
        .out_bit              (out_bit[gi]),
        .pin_in               (pins[gi]),
        .alt_in               (alts[gi]),
        .ccr_wr               (ccr_wr[gi]),
        .ccr_wdata            (ccr_wdata),
        .ccr_r                (ccr_value[16*gi +: 16]),
        .cc_evt               (cc_evt[gi]),
        .out_r                (cmp_out[gi])
      );
    end
  endgenerate

  // ========================================================================
  // interrupt flags and vector word

  // highest pending shared source: channel one, channel two, overflow
  // [R14] [R15] vector encode
  always @* begin
    iv_nxt  = `CCTA_IV_NONE;
    ack_clr = 4'h0;
    if (flag_r[1]) begin
      iv_nxt  = `CCTA_IV_CC1;
      ack_clr = 4'h2;
    end else if (flag_r[2]) begin
      iv_nxt  = `CCTA_IV_CC2;
      ack_clr = 4'h4;
    end else if (flag_r[3]) begin
      iv_nxt  = `CCTA_IV_OVF;
      ack_clr = 4'h8;
    end
  end

  // sticky flags; a new event in the clearing cycle keeps the flag set
  // [R16] set wins
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 4'h0;
    end else begin
      flag_r <= (flag_r & ~(flag_clr | (iv_ack ? ack_clr : 4'h0))) |
                {tick & ovf_evt, cc_evt};
    end
  end

  assign flags       = flag_r;
  assign int_vector  = iv_nxt;
  // [R13] two request lines
  assign irq_cc_zero = flag_r[0] & irq_en[0];
  assign irq_shared  = |(flag_r[3:1] & irq_en[3:1]);

endmodule // ccta_timer

`default_nettype wire

// File: testbench/ccta_partner.sv
/*
 * event source model: count clock sources and capture pins, changed at
 * the falling edge; compare outputs are taken in as a load only.
 * assumes its tasks are called at a falling edge of ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// sources and pins
module ccta_partner (
  // clock and load
  input  wire logic       ref_clk,
  input  wire logic [2:0] cmp_out,
  // count sources, standing low between bursts
  output wire logic       ext_count_clk_a,
  output wire logic       aux_clk,
  output wire logic       peripheral_sub_clock,
  output wire logic       ext_count_clk_b,
  // event pins
  output wire logic       event_pin_zero,
  output wire logic       event_pin_one,
  output wire logic       event_pin_two
);
  logic [3:0] src = 4'h0;
  logic [2:0] pin = 3'h0;

  // source index follows the selector code
  assign {ext_count_clk_b, peripheral_sub_clock, aux_clk, ext_count_clk_a} = src;
  assign {event_pin_two, event_pin_one, event_pin_zero} = pin;

  // n rising edges, two cycles high and two low, slower than half the clock
  task automatic src_edges(input logic [1:0] sel, input int n);
    repeat (n) begin
      src[sel] = 1'b1;
      repeat (2) @(negedge ref_clk);
      src[sel] = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask

  // one event pin to a level
  task automatic set_pin(input int i, input logic v);
    pin[i] = v;
  endtask
endmodule // ccta_partner

`default_nettype wire

// File: testbench/ccta_timer_assertions.sv
/*
 * port checks of the three-channel capture/compare timer.
 * assumes it is bound to ccta_timer; one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccta_consts.vh"

// ==========================================================================
// port checker
module ccta_timer_assertions #(
  parameter CHANS = 3
) (
  // clock and reset
  input wire logic                ref_clk,
  input wire logic                rst_n,
  // counter
  input wire logic [1:0]          mode_sel,
  input wire logic                cnt_clr,
  input wire logic                cnt_wr,
  input wire logic [15:0]         cnt_wdata,
  input wire logic [15:0]         cnt_value,
  // channel zero capture
  input wire logic [CHANS-1:0]    cap_mode,
  input wire logic [2*CHANS-1:0]  cap_edge,
  input wire logic [2*CHANS-1:0]  capture_input_select,
  input wire logic [16*CHANS-1:0] ccr_value,
  input wire logic                event_pin_zero,
  // flags and requests
  input wire logic [3:0]          irq_en,
  input wire logic [3:0]          flag_clr,
  input wire logic                iv_ack,
  input wire logic [3:0]          flags,
  input wire logic [3:0]          int_vector,
  input wire logic                irq_cc_zero,
  input wire logic                irq_shared
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // no software access to the counter this cycle
  wire quiet = !cnt_wr && !cnt_clr;

  // ffff left behind in continuous mode, then a change
  sequence wrap_s;
    mode_sel == `CCTA_MODE_CONT && quiet && cnt_value == 16'hffff
      ##1 cnt_value != 16'hffff;
  endsequence
  // rising edge on pin zero while channel zero captures rises
  sequence rise0_s;
    cap_mode[0] && cap_edge[1:0] == `CCTA_EDGE_RISE
      && capture_input_select[1:0] == `CCTA_CIS_PIN && !event_pin_zero ##1 event_pin_zero;
  endsequence

  // counter access, counting and modes
  cnt_write_a: assert property (cnt_wr && !cnt_clr |=> cnt_value == $past(cnt_wdata))
    else $error("counter write not taken");
  cnt_clear_a: assert property (cnt_clr |=> cnt_value == 16'h0000)
    else $error("counter clear not taken");
  stop_hold_a: assert property (mode_sel == `CCTA_MODE_STOP && quiet |=> $stable(cnt_value))
    else $error("counter moved while stopped");
  count_step_a: assert property ((mode_sel == `CCTA_MODE_UP || mode_sel == `CCTA_MODE_CONT)
    && quiet ##1 $changed(cnt_value)
    |-> cnt_value == $past(cnt_value) + 16'h0001 || cnt_value == 16'h0000)
    else $error("counter step is not one");
  cont_wrap_a: assert property (wrap_s |-> cnt_value == 16'h0000 ##[0:1] flags[3])
    else $error("continuous wrap wrong");
  // capture and flags
  cap_rise_a: assert property (rise0_s |-> ##1 ccr_value[15:0] == $past(cnt_value) && flags[0])
    else $error("rising capture missed");
  irq_zero_a: assert property (irq_cc_zero == (flags[0] && irq_en[0]))
    else $error("channel zero request wrong");
  irq_shared_a: assert property (irq_shared == |(flags[3:1] & irq_en[3:1]))
    else $error("shared request wrong");
  vector_word_a: assert property (int_vector == (flags[1] ? `CCTA_IV_CC1 : flags[2] ? `CCTA_IV_CC2
    : flags[3] ? `CCTA_IV_OVF : `CCTA_IV_NONE))
    else $error("vector word wrong");
  flag_sticky_a: assert property (flags[0] && !flag_clr[0] |=> flags[0])
    else $error("flag dropped by itself");
  ack_keeps_a: assert property (iv_ack && flags[1] && flags[2] && !flag_clr[2] |=> flags[2])
    else $error("acknowledge cleared a lower source");
endmodule // ccta_timer_assertions

`default_nettype wire

// File: testbench/ccta_timer_test.sv
/*
 * self-checking bench of the three-channel timer: sources, prescaler,
 * modes, capture, outputs, flags and vector word.
 * assumes the design, the checker and the source model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccta_consts.vh"

// ==========================================================================
// bench top
module ccta_timer_test;
  localparam int CHANS = 3;
  typedef struct { logic [3:0] kind; logic [15:0] exp; } ccta_note_t;
  logic        ref_clk, rst_n, cnt_clr, cnt_wr, iv_ack, irq_cc_zero, irq_shared, b;
  logic        ext_count_clk_a, ext_count_clk_b, aux_clk, peripheral_sub_clock;
  logic        event_pin_zero, event_pin_one, event_pin_two;
  logic [1:0]  src_sel, div_sel, mode_sel;
  logic [2:0]  cap_mode, out_bit, ccr_wr, cmp_out;
  logic [3:0]  irq_en, flag_clr, flags, int_vector;
  logic [5:0]  cap_edge, capture_input_select;
  logic [8:0]  out_mode;
  logic [15:0] cnt_wdata, ccr_wdata, cnt_value, r;
  logic [47:0] ccr_value;
  logic [15:0] exp_ccr [3];
  int          n_mismatch, tests_run;
  ccta_note_t  notes [$];

  ccta_timer #(.CHANS(CHANS)) ccta_timer_inst (.*);
  ccta_partner ccta_partner_inst (.*);

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // output picked by a note kind
  function automatic logic [15:0] pick(input logic [3:0] k);
    case (k)
      4'h0: pick = cnt_value;
      4'h1, 4'h2, 4'h3: pick = ccr_value[16*(k-4'h1) +: 16];
      4'h4: pick = {12'h000, flags};
      4'h5: pick = {12'h000, int_vector};
      4'h6: pick = {13'h0000, cmp_out};
      default: pick = {14'h0000, irq_shared, irq_cc_zero};
    endcase
  endfunction

  // compare after each edge settles, oldest note first
  always @(posedge ref_clk) begin
    #2;
    while (notes.size() > 0) check_val(notes.pop_front());
  end

  task check_val(input ccta_note_t nt);
    tests_run++;
    if (pick(nt.kind) !== nt.exp) begin
      n_mismatch++;
      $display("ERROR at %0t: expected %h got %h", $time, nt.exp, pick(nt.kind));
    end
  endtask

  // driver helpers, all changes at the falling edge
  task put(input int k, input logic [15:0] v);
    notes.push_back('{4'(k), v});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task load_cnt(input logic [15:0] v);
    cnt_wdata = v;
    cnt_wr = 1'b1;
    cyc(1);
    cnt_wr = 1'b0;
  endtask
  task load_ccr(input int c, input logic [15:0] v);
    ccr_wdata = v;
    ccr_wr = 3'(1 << c);
    cyc(1);
    ccr_wr = 3'h0;
  endtask
  // flag clear pulse; written directly so it reaches the design in its cycle
  task pulse(input logic [3:0] v);
    flag_clr = v;
    cyc(1);
    flag_clr = 4'h0;
  endtask
  // one idle edge first so that pending notes see settled outputs
  task tick_from(input logic [15:0] v, input int n);
    cyc(1);
    load_cnt(v);
    pulse(4'hf);
    ccta_partner_inst.src_edges(2'h2, n);
  endtask
  // capture by pin level, aux clock rise or software selector step
  task cap_try(input int c, input int how, input logic lvl, input logic hit);
    r = 16'($urandom);
    tick_from(r, 0);
    if (how == 0) ccta_partner_inst.set_pin(c, lvl);
    else if (how == 1) ccta_partner_inst.src_edges(2'h1, 1);
    else capture_input_select[2*c +: 2] = `CCTA_CIS_VCC;
    cyc(3);
    if (hit) exp_ccr[c] = r;
    put(c + 1, exp_ccr[c]);
    put(4, hit ? 16'(1 << c) : 16'h0000);
  endtask

  task finish_test;
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog well beyond the some 850 cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial begin
    {rst_n, cnt_clr, cnt_wr, iv_ack, cnt_wdata, ccr_wdata, src_sel, div_sel} = '0;
    {mode_sel, cap_mode, out_bit, ccr_wr, cap_edge, capture_input_select} = '0;
    {out_mode, irq_en, flag_clr} = '0;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(89971));
    cyc(20);
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++) put(k, 16'h0000);
    cyc(1);
    // word write, hold while stopped, clear
    src_sel = `CCTA_SRC_PERIPH;
    load_cnt(16'($urandom));
    ccta_partner_inst.src_edges(2'h2, 3);
    put(0, cnt_wdata);
    pulse(4'h0);
    cnt_clr = 1'b1;
    cyc(1);
    cnt_clr = 1'b0;
    put(0, 16'h0000);
    // every source and every divider, counter cleared each time
    mode_sel = `CCTA_MODE_CONT;
    for (int s = 0; s < 4; s++)
      for (int d = 0; d < 4; d++) begin
        {src_sel, div_sel} = {2'(s), 2'(d)};
        cnt_clr = 1'b1;
        cyc(1);
        cnt_clr = 1'b0;
        ccta_partner_inst.src_edges(2'(s), 8);
        put(0, 16'(8 >> d));
        cyc(1);
      end
    // up mode wraps at channel zero, continuous at ffff, up/down turns
    {src_sel, div_sel, irq_en} = {`CCTA_SRC_PERIPH, 2'h0, 4'h8};
    load_ccr(1, 16'h1234);
    load_ccr(2, 16'h1234);
    load_ccr(0, 16'h0005);
    mode_sel = `CCTA_MODE_UP;
    tick_from(16'h0005, 1);
    put(0, 16'h0000);
    put(5, {12'h000, `CCTA_IV_OVF});
    put(7, 16'h0002);
    mode_sel = `CCTA_MODE_CONT;
    tick_from(16'hffff, 1);
    put(4, 16'h0008);
    mode_sel = `CCTA_MODE_UPDN;
    tick_from(16'h0004, 2);
    put(0, 16'h0004);
    cyc(1);
    ccta_partner_inst.src_edges(2'h2, 4);
    put(4, 16'h0009);
    // compare outputs, shared vector order and acknowledge
    mode_sel = `CCTA_MODE_CONT;
    b = 1'($urandom);
    {out_bit, irq_en} = {2'b00, b, 4'h1};
    out_mode = {`CCTA_OUT_TGL, `CCTA_OUT_SET, `CCTA_OUT_BIT};
    for (int c = 0; c < 3; c++) load_ccr(c, 16'h0003);
    tick_from(16'h0000, 3);
    put(4, 16'h0007);
    put(6, {13'h0000, 2'b11, b});
    put(5, 16'h0002);
    put(7, 16'h0001);
    pulse(4'h0);
    iv_ack = 1'b1;
    cyc(1);
    iv_ack = 1'b0;
    put(5, 16'h0004);
    // capture on chosen edges, none disables
    {mode_sel, cap_mode} = {`CCTA_MODE_STOP, 3'h7};
    exp_ccr = '{16'h0003, 16'h0003, 16'h0003};
    for (int c = 0; c < 3; c++)
      for (int e = 0; e < 4; e++) begin
        cap_edge = 6'(e << (2 * c));
        cap_try(c, 0, 1'b1, e[0]);
        cap_try(c, 0, 1'b0, e[1]);
      end
    {capture_input_select, cap_edge} = {6'h10, 6'h10};
    cap_try(2, 1, 1'b0, 1'b1);
    {capture_input_select, cap_edge} = {6'h28, 6'h04};
    cap_try(1, 2, 1'b0, 1'b1);
    // remaining output unit modes, own match at 2 on channels one and two, period match at 4
    {mode_sel, cap_mode, out_bit} = {`CCTA_MODE_UP, 3'h0, 3'b101};
    out_mode = 9'h000;
    load_ccr(0, 16'h0004);
    load_ccr(1, 16'h0002);
    load_ccr(2, 16'h0002);
    out_mode = {`CCTA_OUT_RST_SET, `CCTA_OUT_SET_RST, `CCTA_OUT_RST};
    tick_from(16'h0000, 2);
    put(6, 16'h0003);
    ccta_partner_inst.src_edges(2'h2, 2);
    put(6, 16'h0004);
    out_mode = {`CCTA_OUT_TGL_SET, `CCTA_OUT_TGL_RST, `CCTA_OUT_TGL};
    ccta_partner_inst.src_edges(2'h2, 3);
    put(6, 16'h0002);
    ccta_partner_inst.src_edges(2'h2, 2);
    put(6, 16'h0005);
    cyc(3);
    finish_test();
  end
endmodule // ccta_timer_test

bind ccta_timer ccta_timer_assertions #(.CHANS(CHANS)) ccta_timer_assertions_inst (.*);

`default_nettype wire
